//--- acnd_alu.sv
`timescale 1ns/1ps
module acnd_alu (
    input  wire logic [acnd_pkg::ACC_W-1:0] minuend,    // left operand
    input  wire logic [acnd_pkg::ACC_W-1:0] subtrahend, // right operand
    output logic [acnd_pkg::ACC_W-1:0]      difference, // minuend - subtrahend
    output acnd_pkg::acnd_flags_s           flags       // flags of the difference
);
    logic [acnd_pkg::ACC_W:0] wide;

    always_comb begin
        wide = {1'b0, minuend} - {1'b0, subtrahend};
        difference = wide[acnd_pkg::ACC_W-1:0];
        // carry is the borrow out
        flags.carry = wide[acnd_pkg::ACC_W];
        // signed overflow of the subtraction
        flags.overflow = (minuend[acnd_pkg::ACC_W-1] ^ subtrahend[acnd_pkg::ACC_W-1])
                       & (minuend[acnd_pkg::ACC_W-1] ^ difference[acnd_pkg::ACC_W-1]);
        flags.sign = difference[acnd_pkg::ACC_W-1];
        flags.zero = (difference == acnd_pkg::ACC_RESET);
    end
endmodule

//--- acnd_core.sv
`timescale 1ns/1ps
// Overview of operation
// - compare computes second minus first; accumulators stay unchanged, only flags stored.
// - compare sets carry, overflow, sign and zero from the subtraction.
// - first operand is x, y, z or r; second is accumulator or 24-bit immediate.
// - accumulator compare takes 1 cycle; immediate compare takes 4 cycles.
// - negate writes inverse plus one, updates sign and zero only, takes 2 cycles.
// - decrement subtracts one, updates all four flags, takes 1 cycle.
// - watchdog-clear opcode pulses the watchdog clear strobe, alters no flag.
// - flag C is carry, flag O is overflow.
module acnd_core (
    input  wire logic                          core_clk,                       // core clock
    input  wire logic                          reset,                          // async reset
    input  wire logic                          instr_valid,                    // decoded instr valid
    input  wire acnd_pkg::acnd_instr_s         instr,                          // decoded instr
    output logic                               instr_ready,                    // may accept
    output logic                               instr_done,                     // retire pulse
    output logic                               watchdog_clear,                 // wdt restart
    output acnd_pkg::acnd_flags_s              carry_overflow_sign_zero_flags, // flags
    input  wire logic [acnd_pkg::ADDR_W-1:0]   bus_addr,                       // reg address
    input  wire logic [acnd_pkg::DATA_W-1:0]   bus_wdata,                      // write data
    input  wire logic                          bus_write,                      // write strobe
    input  wire logic                          bus_read,                       // read strobe
    output logic [acnd_pkg::DATA_W-1:0]        bus_rdata                       // read data
);
    logic [acnd_pkg::ACC_W-1:0] acc [4];
    logic                       busy;
    logic [acnd_pkg::CNT_W-1:0] remaining;
    acnd_pkg::acnd_instr_s      held;
    acnd_pkg::acnd_instr_s      cur;
    logic                       accept;
    logic                       commit;
    logic [acnd_pkg::ACC_W-1:0] first_val;
    logic [acnd_pkg::ACC_W-1:0] second_val;
    logic [acnd_pkg::ACC_W-1:0] minuend;
    logic [acnd_pkg::ACC_W-1:0] subtrahend;
    logic [acnd_pkg::ACC_W-1:0] difference;
    acnd_pkg::acnd_flags_s      alu_flags;
    acnd_pkg::acnd_flags_s      next_flags;
    logic                       writes_acc;
    logic [acnd_pkg::CNT_W-1:0] cyc_new;
    logic [2:0]                 bus_hit;
    logic [3:0]                 instr_we;
    logic [3:0]                 bus_we;

    function automatic logic [acnd_pkg::CNT_W-1:0] op_cycles(input acnd_pkg::acnd_instr_s i);
        case (i.op)
            acnd_pkg::ACND_OP_COMPARE: begin
                op_cycles = i.second_is_imm ? acnd_pkg::CYC_CMP_IMM
                                            : acnd_pkg::CYC_CMP_ACC;
            end
            acnd_pkg::ACND_OP_NEGATE:    op_cycles = acnd_pkg::CYC_NEGATE;
            acnd_pkg::ACND_OP_DECREMENT: op_cycles = acnd_pkg::CYC_DECR;
            acnd_pkg::ACND_OP_WDT_CLEAR: op_cycles = acnd_pkg::CYC_WDT;
            default:                     op_cycles = acnd_pkg::CYC_DECR;
        endcase
    endfunction

    // bus address to accumulator index; top bit marks a hit
    function automatic logic [2:0] acc_decode(input logic [acnd_pkg::ADDR_W-1:0] a);
        case (a)
            acnd_pkg::REG_ACC_X: acc_decode = {1'b1, acnd_pkg::SEL_X};
            acnd_pkg::REG_ACC_Y: acc_decode = {1'b1, acnd_pkg::SEL_Y};
            acnd_pkg::REG_ACC_Z: acc_decode = {1'b1, acnd_pkg::SEL_Z};
            acnd_pkg::REG_ACC_R: acc_decode = {1'b1, acnd_pkg::SEL_R};
            default:             acc_decode = 3'h0;
        endcase
    endfunction

    assign instr_ready = !busy;
    assign accept      = instr_valid && !busy;
    assign cyc_new     = op_cycles(instr);
    assign cur         = busy ? held : instr;
    // one decode of the bus address serves both write and read
    assign bus_hit     = acc_decode(bus_addr);
    // single-cycle ops retire on acceptance, others on their last cycle
    assign commit      = (accept && cyc_new == acnd_pkg::CYC_DECR)
                       || (busy && remaining == acnd_pkg::CYC_DECR);

    // operand fetch; only the second operand may be an immediate
    assign first_val  = acc[cur.accumulator_select];
    assign second_val = cur.second_is_imm ? cur.imm : acc[cur.second_select];

    // operand routing into the shared subtractor
    always_comb begin
        case (cur.op)
            acnd_pkg::ACND_OP_COMPARE: begin
                minuend    = second_val;
                subtrahend = first_val;
            end
            acnd_pkg::ACND_OP_NEGATE: begin
                minuend    = acnd_pkg::ACC_RESET;
                subtrahend = first_val;
            end
            acnd_pkg::ACND_OP_DECREMENT: begin
                minuend    = first_val;
                subtrahend = acnd_pkg::ACC_ONE;
            end
            default: begin
                minuend    = acnd_pkg::ACC_RESET;
                subtrahend = acnd_pkg::ACC_RESET;
            end
        endcase
    end

    acnd_alu u_alu (
        .minuend    (minuend),
        .subtrahend (subtrahend),
        .difference (difference),
        .flags      (alu_flags)
    );

    // flag merge; negate keeps carry and overflow
    always_comb begin
        next_flags = carry_overflow_sign_zero_flags;
        writes_acc = 1'b0;
        case (cur.op)
            acnd_pkg::ACND_OP_COMPARE: begin
                next_flags = alu_flags;
            end
            acnd_pkg::ACND_OP_DECREMENT: begin
                next_flags = alu_flags;
                writes_acc = 1'b1;
            end
            acnd_pkg::ACND_OP_NEGATE: begin
                next_flags.sign = alu_flags.sign;
                next_flags.zero = alu_flags.zero;
                writes_acc      = 1'b1;
            end
            acnd_pkg::ACND_OP_WDT_CLEAR: begin
                next_flags = carry_overflow_sign_zero_flags;
            end
            default: begin
                next_flags = carry_overflow_sign_zero_flags;
            end
        endcase
    end

    // multi-cycle sequencing
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy      <= 1'b0;
            remaining <= '0;
            held      <= '0;
        end else if (accept && cyc_new != acnd_pkg::CYC_DECR) begin
            busy      <= 1'b1;
            remaining <= cyc_new - acnd_pkg::CYC_DECR;
            held      <= instr;
        end else if (busy) begin
            remaining <= remaining - acnd_pkg::CYC_DECR;
            busy      <= (remaining != acnd_pkg::CYC_DECR);
        end
    end

    // flags change only when an instruction retires
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            carry_overflow_sign_zero_flags <= acnd_pkg::FLAGS_RESET;
        end else if (commit) begin
            carry_overflow_sign_zero_flags <= next_flags;
        end
    end

    // accumulators; a retiring instruction wins over a bus write
    generate
        for (genvar g = 0; g < 4; g++) begin : g_acc
            assign instr_we[g] = commit && writes_acc && cur.accumulator_select == 2'(g);
            assign bus_we[g]   = bus_write && bus_hit == {1'b1, 2'(g)};
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    acc[g] <= acnd_pkg::ACC_RESET;
                end else if (instr_we[g]) begin
                    acc[g] <= difference;
                end else if (bus_we[g]) begin
                    acc[g] <= bus_wdata[acnd_pkg::ACC_W-1:0];
                end
            end
        end
    endgenerate

    // retire pulse, registered from commit, raised at the retiring edge
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= commit;
        end
    end

    // watchdog restart strobe, raised with the retire pulse
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            watchdog_clear <= 1'b0;
        end else begin
            watchdog_clear <= commit && cur.op == acnd_pkg::ACND_OP_WDT_CLEAR;
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bus_rdata <= '0;
        end else if (bus_read) begin
            if (bus_addr == acnd_pkg::REG_FLAGS) begin
                bus_rdata <= '0;
                bus_rdata[acnd_pkg::FLAG_CARRY_BIT]    <= carry_overflow_sign_zero_flags.carry;
                bus_rdata[acnd_pkg::FLAG_OVERFLOW_BIT] <= carry_overflow_sign_zero_flags.overflow;
                bus_rdata[acnd_pkg::FLAG_SIGN_BIT]     <= carry_overflow_sign_zero_flags.sign;
                bus_rdata[acnd_pkg::FLAG_ZERO_BIT]     <= carry_overflow_sign_zero_flags.zero;
            end else if (bus_hit[2]) begin
                bus_rdata <= {8'h00, acc[bus_hit[1:0]]};
            end else begin
                bus_rdata <= '0;
            end
        end else begin
            bus_rdata <= '0;
        end
    end

endmodule

//--- acnd_core_chk.sv
`timescale 1ns/1ps
module acnd_core_chk (
    input wire logic                  core_clk,                       // clk
    input wire logic                  reset,                          // rst
    input wire logic                  instr_valid,                    // valid
    input wire acnd_pkg::acnd_instr_s instr,                          // instr
    input wire logic                  instr_ready,                    // ready
    input wire logic                  instr_done,                     // done
    input wire logic                  watchdog_clear,                 // wdt
    input wire acnd_pkg::acnd_flags_s carry_overflow_sign_zero_flags, // flags
    input wire logic [7:0]            bus_addr,                       // addr
    input wire logic [31:0]           bus_wdata,                      // wdata
    input wire logic                  bus_write,                      // wr
    input wire logic                  bus_read,                       // rd
    input wire logic [31:0]           bus_rdata                       // rdata
);
    wire acnd_pkg::acnd_flags_s f = carry_overflow_sign_zero_flags;
    wire take = instr_valid && instr_ready;
    wire wdt = take && instr.op == acnd_pkg::ACND_OP_WDT_CLEAR;
    wire neg = take && instr.op == acnd_pkg::ACND_OP_NEGATE;
    wire imm = take && instr.op == acnd_pkg::ACND_OP_COMPARE && instr.second_is_imm;
    sequence s_busy3; !instr_ready [*3]; endsequence
    sequence s_fin; instr_done && instr_ready; endsequence
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_short_op_len: assert property (take && !wdt && !neg && !imm |=> s_fin)
        else $error("short op late");
    a_imm_cmp_len: assert property (imm |=> s_busy3 ##1 s_fin)
        else $error("imm compare length");
    a_two_cycle_len: assert property (wdt || neg |=> !instr_ready ##1 s_fin)
        else $error("two cycle op length");
    a_wdt_pulse: assert property (wdt |=> ##1 watchdog_clear)
        else $error("no watchdog clear");
    a_wdt_own_op: assert property (watchdog_clear |-> instr_done && !$past(instr_ready))
        else $error("stray watchdog clear");
    a_wdt_flags_kept: assert property (wdt |=> ##1 $stable(f))
        else $error("watchdog clear hit flags");
    a_neg_co_kept: assert property (neg |=> ##1 $stable({f.carry, f.overflow}))
        else $error("negate hit carry or overflow");
    a_flags_at_retire: assert property ($changed(f) |-> instr_done)
        else $error("flags moved outside retire");
    a_rdata_idle: assert property (!bus_read |=> bus_rdata == 32'h0)
        else $error("read data without strobe");
endmodule

bind acnd_core acnd_core_chk u_chk (.core_clk(core_clk), .reset(reset),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .instr_done(instr_done), .watchdog_clear(watchdog_clear),
    .carry_overflow_sign_zero_flags(carry_overflow_sign_zero_flags), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata));

//--- acnd_core_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module acnd_core_tb;
    logic                  core_clk = 0, reset = 1, instr_valid = 0, bus_write = 0, bus_read = 0;
    acnd_pkg::acnd_instr_s instr = '0;
    logic [7:0]            bus_addr = '0;
    logic [31:0]           bus_wdata = '0, bus_rdata;
    logic                  instr_ready, instr_done, watchdog_clear;
    acnd_pkg::acnd_flags_s flags, ef = '0;
    logic [23:0]           m [4] = '{default: '0};
    int                    error_cnt = 0, cmp_count = 0;
    always #4 core_clk = ~core_clk;
    acnd_core DUT (.core_clk(core_clk), .reset(reset), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done),
        .watchdog_clear(watchdog_clear), .carry_overflow_sign_zero_flags(flags),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
        .bus_read(bus_read), .bus_rdata(bus_rdata));
    function automatic acnd_pkg::acnd_flags_s f_sub(logic [23:0] a, logic [23:0] b);
        logic [23:0] d;
        d = a - b;
        return '{carry: a < b, overflow: a[23] != b[23] && d[23] != a[23],
                 sign: d[23], zero: d == 24'h0};
    endfunction
    // extra cycles after the accept edge until the retire pulse shows
    function automatic int exp_lat(acnd_pkg::acnd_op_e o, logic i);
        case (o)
            acnd_pkg::ACND_OP_COMPARE:   return i ? 3 : 0;
            acnd_pkg::ACND_OP_DECREMENT: return 0;
            default:                     return 1;
        endcase
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        bus_write <= 1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_write <= 0;
        if (a >= 8'h04 && a <= 8'h10 && a[1:0] == 2'h0) m[a[4:2] - 1] = d[23:0];
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge core_clk);
        bus_read <= 1;
        bus_addr <= a;
        @(posedge core_clk);
        bus_read <= 0;
        #1 `CHK("bus_rdata", e, bus_rdata)
    endtask
    task automatic chk_acc();
        for (int s = 0; s < 4; s++) rd(8'(4 + 4 * s), {8'h0, m[s]});
        rd(acnd_pkg::REG_FLAGS, {28'h0, ef});
    endtask
    task automatic op(acnd_pkg::acnd_op_e o, logic [1:0] s, logic i, logic [1:0] s2,
                      logic [23:0] v);
        int n;
        @(posedge core_clk);
        instr_valid <= 1;
        instr <= '{op: o, accumulator_select: s, second_is_imm: i, second_select: s2, imm: v};
        @(posedge core_clk);
        instr_valid <= 0;
        n = 0;
        #1;
        while (instr_done !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1 n++;
        end
        `CHK("latency", exp_lat(o, i), n)
        `CHK("watchdog_clear", o == acnd_pkg::ACND_OP_WDT_CLEAR, watchdog_clear)
        case (o)
            acnd_pkg::ACND_OP_COMPARE: ef = f_sub(i ? v : m[s2], m[s]);
            acnd_pkg::ACND_OP_NEGATE: begin
                m[s] = -m[s];
                ef.sign = m[s][23];
                ef.zero = m[s] == 24'h0;
            end
            acnd_pkg::ACND_OP_DECREMENT: begin
                ef = f_sub(m[s], 24'h1);
                m[s] = m[s] - 24'h1;
            end
            default: ;
        endcase
        `CHK("flags", ef, flags)
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        logic [23:0] cv [5] = '{24'h0, 24'h1, 24'h800000, 24'h7fffff, 24'hffffff};
        logic [1:0] s;
        void'($urandom(11414));
        repeat (20) @(posedge core_clk);
        reset <= 0;
        chk_acc();
        wr(acnd_pkg::REG_FLAGS, 32'hf);
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 32'h0);
        for (int k = 0; k < 60; k++) begin
            s = 2'($urandom_range(3));
            wr(8'(4 + 4 * s), (k < 25) ? {8'h5a, cv[k % 5]} : $urandom);
            // first four rounds walk every op code
            op(k < 4 ? acnd_pkg::acnd_op_e'(k) : acnd_pkg::acnd_op_e'($urandom_range(3)), s,
               1'($urandom_range(1)), 2'($urandom_range(3)),
               k[0] ? cv[k % 5] : 24'($urandom));
            chk_acc();
        end
        // two decrements back to back, a bus write to x colliding with the first
        @(posedge core_clk);
        instr_valid <= 1;
        instr <= '{op: acnd_pkg::ACND_OP_DECREMENT, default: '0};
        bus_write <= 1;
        bus_addr <= acnd_pkg::REG_ACC_X;
        bus_wdata <= 32'h00123456;
        @(posedge core_clk);
        bus_write <= 0;
        @(posedge core_clk);
        instr_valid <= 0;
        ef = f_sub(m[0] - 24'h1, 24'h1);
        m[0] = m[0] - 24'h2;
        #1 chk_acc();
        // program run ends: watchdog restart right before the halt
        op(acnd_pkg::ACND_OP_WDT_CLEAR, 2'h0, 1'b0, 2'h0, 24'h0);
        conclude();
    end
    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end
endmodule

//--- acnd_pkg.sv
package acnd_pkg;

    localparam int ACC_W = 24;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 3;

    // cycles per instruction
    localparam logic [CNT_W-1:0] CYC_CMP_ACC = 3'h1;
    localparam logic [CNT_W-1:0] CYC_CMP_IMM = 3'h4;
    localparam logic [CNT_W-1:0] CYC_NEGATE  = 3'h2;
    localparam logic [CNT_W-1:0] CYC_DECR    = 3'h1;
    localparam logic [CNT_W-1:0] CYC_WDT     = 3'h2;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_ACC_X = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ACC_Y = 8'h08;
    localparam logic [ADDR_W-1:0] REG_ACC_Z = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_ACC_R = 8'h10;

    // flag bit positions in the flags register
    localparam int FLAG_ZERO_BIT     = 0;
    localparam int FLAG_SIGN_BIT     = 1;
    localparam int FLAG_OVERFLOW_BIT = 2;
    localparam int FLAG_CARRY_BIT    = 3;

    localparam logic [ACC_W-1:0] ACC_RESET = 24'h000000;
    localparam logic [ACC_W-1:0] ACC_ONE   = 24'h000001;

    // accumulator select codes
    localparam logic [1:0] SEL_X = 2'h0;
    localparam logic [1:0] SEL_Y = 2'h1;
    localparam logic [1:0] SEL_Z = 2'h2;
    localparam logic [1:0] SEL_R = 2'h3;

    typedef enum logic [1:0] {
        ACND_OP_WDT_CLEAR,
        ACND_OP_COMPARE,
        ACND_OP_NEGATE,
        ACND_OP_DECREMENT
    } acnd_op_e;

    typedef struct packed {
        acnd_op_e         op;
        logic [1:0]       accumulator_select;
        logic             second_is_imm;
        logic [1:0]       second_select;
        logic [ACC_W-1:0] imm;
    } acnd_instr_s;

    typedef struct packed {
        logic carry;
        logic overflow;
        logic sign;
        logic zero;
    } acnd_flags_s;

    localparam acnd_flags_s FLAGS_RESET = 4'h0;

endpackage
